/* File: hdl/cwd_defs.svh */
// Register offsets, field positions and timing constants of the watchdog block
`ifndef CWD_DEFS_SVH
`define CWD_DEFS_SVH
`define CWD_OFS_RESTART_FLAGS  8'h09
`define CWD_OFS_CONTROL        8'h0a
`define CWD_BIT_ENABLE         7
`define CWD_BIT_WD_FLAG        7
`define CWD_BIT_POR_FLAG       6
`define CWD_BIT_LB_FLAG        5
`define CWD_RESTART_PATTERN    4'ha
`define CWD_TIMEOUT_INVALID    5'h00
`define CWD_TIMEOUT_DISABLE    5'h1f
`define CWD_CONTROL_RESET      8'h00
`define CWD_CLK_HZ             50000000
`define CWD_STEP_MS            100
`define CWD_STEP_CYCLES        ((`CWD_CLK_HZ / 1000) * `CWD_STEP_MS)
`define CWD_PULSE_MS           100
`define CWD_PULSE_CYCLES       ((`CWD_CLK_HZ / 1000) * `CWD_PULSE_MS)
`endif

/* File: hdl/cwd_pkg.sv */
// Types shared by the watchdog block
package cwd_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cwd_req_t;
    typedef enum logic [2:0] {
        CWD_IDLE  = 3'b001,
        CWD_RUN   = 3'b010,
        CWD_PULSE = 3'b100
    } cwd_state_t;
endpackage

/* File: hdl/cwd_step_timer.sv */
// Prescaler producing one pulse per timeout step
`timescale 1ns/100ps
module cwd_step_timer #(
    parameter int unsigned STEP_CYCLES = 5000000
) (
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic clear,
    output logic      step
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic        step_next;
    logic        step_reg;

    // Restart clears the prescaler so each step is a full period
    always_comb
    begin
        cnt_next  = cnt_reg + 32'h1;
        step_next = 1'b0;
        if (clear)
        begin
            cnt_next = 32'h0;
        end
        else if (cnt_reg == 32'(STEP_CYCLES - 1))
        begin
            cnt_next  = 32'h0;
            step_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_reg  <= 32'h0;
            step_reg <= 1'b0;
        end
        else
        begin
            cnt_reg  <= cnt_next;
            step_reg <= step_next;
        end
    end

    assign step = step_reg;
endmodule // cwd_step_timer

/* File: hdl/cwd_watchdog.sv */
// Watchdog timer with restart pattern and battery-backed reset-cause flags
`timescale 1ns/100ps
`include "cwd_defs.svh"

module cwd_watchdog
    import cwd_pkg::*;
#(
    parameter int unsigned STEP_CYCLES  = `CWD_STEP_CYCLES,
    parameter int unsigned PULSE_CYCLES = `CWD_PULSE_CYCLES
) (
    input  wire logic     ref_clk,
    input  wire logic     arst_n,
    input  wire logic     backup_arst_n,
    input  wire logic     supply_low,
    input  wire logic     backup_supply_low,
    input  wire cwd_req_t req,
    output logic [7:0]    rdata,
    output logic          rst_out_n,
    output logic          wd_expired
);
    logic [7:0]  ctrl_reg;
    logic [7:0]  ctrl_next;
    logic [4:0]  load_reg;
    logic [4:0]  load_next;
    logic [4:0]  steps_reg;
    logic [4:0]  steps_next;
    logic        wd_reset_flag_reg;
    logic        wd_reset_flag_next;
    logic        por_flag_reg;
    logic        por_flag_next;
    logic        low_backup_flag_reg;
    logic        low_backup_flag_next;
    logic        lb_armed_reg;
    logic        lb_armed_next;
    logic [31:0] pulse_reg;
    logic [31:0] pulse_next;
    cwd_state_t  state_reg;
    cwd_state_t  state_next;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;
    logic        rst_n_reg;
    logic        rst_n_next;
    logic        exp_reg;
    logic        exp_next;
    logic        restart;
    logic        step_clear;
    logic        step;
    logic        expire;
    logic        wr_flags;
    logic        wd_enable_bit;
    logic [4:0]  wd_timeout_field;

    // Decode an address against a register offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // Map a timeout code to a number of 100 ms steps
    function automatic logic [4:0] steps_of(input logic [4:0] code);
        return (code == `CWD_TIMEOUT_INVALID) ? 5'h01 : code;
    endfunction

    assign wd_enable_bit    = ctrl_reg[`CWD_BIT_ENABLE];
    assign wd_timeout_field = ctrl_reg[4:0];
    assign wr_flags         = req.wr && hit(req.addr, `CWD_OFS_RESTART_FLAGS);
    assign restart          = wr_flags
                              && req.wdata[3:0] == `CWD_RESTART_PATTERN;

    // Prescaler starts afresh on a restart and on the reload after a reset pulse,
    // otherwise the first step of a new count could come early
    assign step_clear = restart || state_reg == CWD_IDLE;

    cwd_step_timer #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_step (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .clear   (step_clear),
        .step    (step)
    );

    // Expiry is reached on the last step of a running count
    assign expire = state_reg == CWD_RUN && step && steps_reg == 5'h01
                    && load_reg != `CWD_TIMEOUT_DISABLE;

    // Control register, timer and reset pulse on the main-supply reset
    always_comb
    begin
        ctrl_next  = ctrl_reg;
        load_next  = load_reg;
        steps_next = steps_reg;
        state_next = state_reg;
        pulse_next = pulse_reg;
        exp_next   = 1'b0;
        rdata_next = rdata_reg;
        if (req.wr && hit(req.addr, `CWD_OFS_CONTROL))
        begin
            ctrl_next = req.wdata & 8'h9f; // Unused bits read zero
        end
        if (req.rd)
        begin
            if (hit(req.addr, `CWD_OFS_CONTROL))
            begin
                rdata_next = ctrl_reg;
            end
            else if (hit(req.addr, `CWD_OFS_RESTART_FLAGS))
            begin
                // Restart nibble is write-only and reads zero
                rdata_next = {wd_reset_flag_reg, por_flag_reg, low_backup_flag_reg, 5'h00};
            end
            else
            begin
                rdata_next = 8'h00;
            end
        end
        unique case (state_reg)
            CWD_IDLE:
            begin
                state_next = CWD_RUN;
                load_next  = wd_timeout_field;
                steps_next = steps_of(wd_timeout_field);
            end
            CWD_RUN:
            begin
                if (restart)
                begin
                    load_next  = wd_timeout_field;
                    steps_next = steps_of(wd_timeout_field);
                end
                else if (expire)
                begin
                    exp_next   = 1'b1;
                    // Free-running when disabled: reload and carry on
                    steps_next = steps_of(load_reg);
                    if (wd_enable_bit)
                    begin
                        state_next = CWD_PULSE;
                        pulse_next = 32'h0;
                    end
                end
                else if (step && load_reg != `CWD_TIMEOUT_DISABLE)
                begin
                    steps_next = steps_reg - 5'h01; // Code 31 freezes the count
                end
            end
            CWD_PULSE:
            begin
                pulse_next = pulse_reg + 32'h1;
                if (pulse_reg == 32'(PULSE_CYCLES - 1))
                begin
                    state_next = CWD_IDLE;
                end
            end
        endcase
        rst_n_next = !(state_next == CWD_PULSE || supply_low);
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_reg  <= `CWD_CONTROL_RESET;
            load_reg  <= 5'h01;
            steps_reg <= 5'h01;
            state_reg <= CWD_IDLE;
            pulse_reg <= 32'h0;
            rdata_reg <= 8'h00;
            rst_n_reg <= 1'b0;
            exp_reg   <= 1'b0;
        end
        else
        begin
            ctrl_reg  <= ctrl_next;
            load_reg  <= load_next;
            steps_reg <= steps_next;
            state_reg <= state_next;
            pulse_reg <= pulse_next;
            rdata_reg <= rdata_next;
            rst_n_reg <= rst_n_next;
            exp_reg   <= exp_next;
        end
    end

    // Cause flags: hardware set wins over a host clear in the same cycle
    always_comb
    begin
        wd_reset_flag_next   = wd_reset_flag_reg;
        por_flag_next        = por_flag_reg;
        low_backup_flag_next = low_backup_flag_reg;
        lb_armed_next        = 1'b1;
        if (wr_flags)
        begin
            // Writing 1 leaves a flag alone, only 0 clears
            wd_reset_flag_next   = wd_reset_flag_reg & req.wdata[`CWD_BIT_WD_FLAG];
            por_flag_next        = por_flag_reg & req.wdata[`CWD_BIT_POR_FLAG];
            low_backup_flag_next = low_backup_flag_reg & req.wdata[`CWD_BIT_LB_FLAG];
        end
        // A restart in the expiry cycle wins, so no pulse and no flag follow
        if (expire && wd_enable_bit && !restart)
        begin
            wd_reset_flag_next = 1'b1;
        end
        if (supply_low)
        begin
            por_flag_next = 1'b1;
        end
        if (!lb_armed_reg && backup_supply_low)
        begin
            low_backup_flag_next = 1'b1; // Sampled once after backup power-up
        end
    end

    // Backup-domain reset only, so main supply loss keeps the flags
    always_ff @(posedge ref_clk or negedge backup_arst_n)
    begin
        if (!backup_arst_n)
        begin
            wd_reset_flag_reg   <= 1'b0;
            por_flag_reg        <= 1'b0;
            low_backup_flag_reg <= 1'b0;
            lb_armed_reg        <= 1'b0;
        end
        else
        begin
            wd_reset_flag_reg   <= wd_reset_flag_next;
            por_flag_reg        <= por_flag_next;
            low_backup_flag_reg <= low_backup_flag_next;
            lb_armed_reg        <= lb_armed_next;
        end
    end

    assign rdata      = rdata_reg;
    assign rst_out_n  = rst_n_reg;
    assign wd_expired = exp_reg;
endmodule // cwd_watchdog

/* File: bench/cwd_watchdog_checker.sv */
// Port-level assertions for the watchdog block
`timescale 1ns/100ps
module cwd_watchdog_checker
    import cwd_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       arst_n,
    input wire logic       backup_arst_n,
    input wire logic       supply_low,
    input wire logic       backup_supply_low,
    input wire cwd_req_t   req,
    input wire logic [7:0] rdata,
    input wire logic       rst_out_n,
    input wire logic       wd_expired
);
    logic en_reg;
    logic en_next;
    logic rs;
    // Mirror of the enable bit, so expiry can be judged
    always_comb
    begin
        en_next = en_reg;
        if (req.wr && req.addr == 8'h0a)
            en_next = req.wdata[7];
    end
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            en_reg <= 1'b0;
        else
            en_reg <= en_next;
    end
    assign rs = req.wr && req.addr == 8'h09 && req.wdata[3:0] == 4'ha;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    supply_rst_a: assert property (supply_low |=> !rst_out_n) else $error("no reset");
    wd_drive_a: assert property (wd_expired && en_reg |-> ##[0:1] !rst_out_n)
        else $error("expiry without reset");
    wd_len_a: assert property (wd_expired && en_reg |=> (!rst_out_n) [*8])
        else $error("reset pulse short");
    dis_quiet_a: assert property (wd_expired && !en_reg && rst_out_n && !supply_low
        |=> rst_out_n) else $error("disabled expiry reset");
    restart_quiet_a: assert property (rs |=> (!wd_expired) [*8])
        else $error("expiry after restart");
    pulse_one_a: assert property (wd_expired |=> !wd_expired)
        else $error("long expiry");
    rise_ok_a: assert property ($rose(rst_out_n) |-> !$past(supply_low))
        else $error("reset released early");
    rdata_hold_a: assert property (!$past(req.rd) |-> $stable(rdata)) else $error("rdata moved");
endmodule // cwd_watchdog_checker
bind cwd_watchdog cwd_watchdog_checker chk (.ref_clk(ref_clk), .arst_n(arst_n),
    .backup_arst_n(backup_arst_n), .supply_low(supply_low),
    .backup_supply_low(backup_supply_low), .req(req), .rdata(rdata),
    .rst_out_n(rst_out_n), .wd_expired(wd_expired));

/* File: bench/cwd_host.sv */
// Host model issuing register accesses
`timescale 1ns/100ps
module cwd_host
    import cwd_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic [7:0] rdata,
    output cwd_req_t       req
);
    initial req = '0;
    // One-cycle write strobe; host writes only 0 to clear flags
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        req <= '0;
    endtask
    // Read data is registered, so it is taken after the edge that follows the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        req <= '0;
        #1 d = rdata;
    endtask
    // Restart pattern, sent before the timeout runs out
    task automatic restart();
        wr(8'h09, 8'h0a);
    endtask
endmodule // cwd_host

/* File: bench/cwd_watchdog_bench.sv */
// Self-checking bench for the watchdog block
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module cwd_watchdog_bench
    import cwd_pkg::*;
;
    logic       ref_clk, arst_n, backup_arst_n, supply_low, backup_supply_low;
    logic       rst_out_n, wd_expired;
    logic [7:0] rdata, d;
    cwd_req_t   req;
    int         errors, checks, c, lows;
    int         codes [4] = '{0, 1, 2, 3};
    int         steps [4] = '{1, 1, 2, 3};
    cwd_watchdog #(.STEP_CYCLES(20), .PULSE_CYCLES(10)) uut (.ref_clk(ref_clk),
        .arst_n(arst_n), .backup_arst_n(backup_arst_n), .supply_low(supply_low),
        .backup_supply_low(backup_supply_low), .req(req), .rdata(rdata),
        .rst_out_n(rst_out_n), .wd_expired(wd_expired));
    cwd_host h (.ref_clk(ref_clk), .rdata(rdata), .req(req));
    always #10 ref_clk = ~ref_clk;
    // Low cycles of the reset output, to prove keep-alive works
    always @(posedge ref_clk)
        if (arst_n && rst_out_n === 1'b0) lows++;
    task automatic wait_exp(input int lim, output int n);
        n = 0;
        do begin @(posedge ref_clk); #1 n++; end while (wd_expired !== 1'b1 && n < lim);
    endtask
    task automatic results();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog: the whole sequence needs about 720 cycles
    initial
    begin
        #200000 errors++;
        results();
    end
    initial
    begin
        ref_clk = 0; arst_n = 0; backup_arst_n = 0; supply_low = 0; backup_supply_low = 1;
        repeat (5) @(posedge ref_clk);
        arst_n <= 1; backup_arst_n <= 1;
        @(posedge ref_clk);
        backup_supply_low <= 0;
        h.rd(8'h0a, d); `CHK(d, 8'h00)
        h.rd(8'h09, d); `CHK(d, 8'h20)
        h.wr(8'h09, 8'he0); h.rd(8'h09, d); `CHK(d, 8'h20)
        h.wr(8'h09, 8'h00); h.rd(8'h09, d); `CHK(d, 8'h00)
        // Disabled timer still expires, with each code timed from its restart
        for (int i = 0; i < 4; i++)
        begin
            h.wr(8'h0a, codes[i][7:0]); h.restart(); wait_exp(500, c);
            `CHK(c >= steps[i] * 20 - 4 && c <= steps[i] * 20 + 2, 1'b1)
            `CHK(rst_out_n, 1'b1)
        end
        h.rd(8'h09, d); `CHK(d, 8'h00)
        h.wr(8'h0a, 8'h03); h.restart(); h.wr(8'h0a, 8'h01); wait_exp(500, c);
        `CHK(c >= 52 && c <= 62, 1'b1)
        h.wr(8'h0a, 8'h1f); h.restart(); wait_exp(300, c); `CHK(c, 300)
        // Enabled, kept alive with a restart whose upper nibble is all ones
        h.wr(8'h0a, 8'h82); h.restart(); lows = 0;
        repeat (4) begin repeat (25) @(posedge ref_clk); h.wr(8'h09, 8'hfa); end
        `CHK(lows, 0)
        repeat (20) @(posedge ref_clk);
        // Expiry stays 40 cycles after the last real restart, 22 of them already spent
        h.wr(8'h09, 8'h05); wait_exp(100, c); `CHK(c >= 14 && c <= 20, 1'b1)
        c = 0;
        while (rst_out_n !== 1'b1 && c < 50) begin @(posedge ref_clk); #1 c++; end
        `CHK(c >= 9 && c <= 11, 1'b1)
        h.rd(8'h09, d); `CHK(d, 8'h80)
        @(posedge ref_clk);
        supply_low <= 1; repeat (3) @(posedge ref_clk); supply_low <= 0;
        h.rd(8'h09, d); `CHK(d, 8'hc0)
        @(posedge ref_clk);
        arst_n <= 0; repeat (2) @(posedge ref_clk); arst_n <= 1;
        h.rd(8'h09, d); `CHK(d, 8'hc0)
        h.wr(8'h09, 8'h00); h.rd(8'h09, d); `CHK(d, 8'h00)
        h.rd(8'h0b, d); `CHK(d, 8'h00)
        results();
    end
endmodule // cwd_watchdog_bench
